/* File: common/sdb_pkg.sv */
/*
  Package for the serial diagnostic byte map: bit positions of the call,
  response and diagnostic bytes, timing constants and the status enum.
  Assumes a single 40 MHz system clock.
*/
package sdb_pkg;
  localparam int CLK_HZ = 40000000;
  // Bit positions of the call byte.
  localparam int CALL_MAGNET = 0;
  localparam int CALL_RESET = 7;
  // Bit positions of the response byte.
  localparam int RSP_OUT_ACTIVE = 0;
  localparam int RSP_CLOSED_POSSIBLE = 1;
  localparam int RSP_LOCKED = 2;
  localparam int RSP_INPUTS = 4;
  localparam int RSP_ACT_VALID = 5;
  localparam int RSP_WARNING = 6;
  localparam int RSP_ERROR = 7;
  // Bit positions shared by the diagnostic warning and error bytes.
  localparam int DG_OUT_A = 0;
  localparam int DG_OUT_B = 1;
  localparam int DG_CROSS = 2;
  localparam int DG_TEMP = 3;
  localparam int DG_ACTUATOR = 4;
  localparam int DG_INTERNAL = 5;
  localparam int DG_COMM = 6;
  localparam int DG_HANDLE = 7;
  // Reset value of every byte.
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Warning escalation time and the one-second tick that measures it.
  localparam int WARN_ESCALATE_MIN = 30;
  localparam int WARN_ESCALATE_S = WARN_ESCALATE_MIN * 60;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  typedef enum logic [1:0] {
    SDB_OK = 2'b00,
    SDB_WARN = 2'b01,
    SDB_FAULT = 2'b10
  } sdb_health_t;
endpackage : sdb_pkg

/* File: common/sdb_tick_if.sv */
/*
  Interface carrying the slow timing enable between the byte map and its
  tick divider. Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
interface sdb_tick_if;
  logic tick;
  logic hold;
  modport src (output tick, input hold);
  modport dst (input tick, output hold);
endinterface : sdb_tick_if

/* File: rtl/sdb_byte_map.sv */
/*
  Status and command byte map of a door interlock's serial diagnostic link.
  The link framing lives elsewhere: it hands over a call byte with a strobe and
  reads the response and diagnostic bytes as levels. All inputs other than rst_n come from
  pins or another domain and are synchronised here.
*/
// Overview of operation
// RULE_01: Every flag is active high.
// RULE_02: Call bit 0 energises the locking magnet.
// RULE_03: Response bit 1: guard closed, operation possible.
// RULE_04: Response bit 2: actuator detected and locked.
// RULE_05: Response bit 4: both upstream safety inputs.
// RULE_06: Turret pulled out: unlocking reported impossible.
// RULE_07: Locking only possible with turret at rest.
// RULE_08: Warning lasting thirty minutes escalates to fault.
// RULE_09: Controller reads diagnostic bytes on warning.
// RULE_10: Warning bit 6 flags gateway communication error.
// RULE_11: Error bit 4 flags actuator fault.
// RULE_12: Bit 7 of both bytes: handle position.
// RULE_13: Error clears on cause gone and reset edge. The code also clears it when the cause is gone and the guard is open.
// RULE_14: Link failure keeps switching condition unchanged.
// RULE_15: Response bits 0,5,6,7: output, actuator, warning, error.
// RULE_16: Diagnostic bits 0-3,5: outputs, short, temperature, internal.
`timescale 1ns/1ps
module sdb_byte_map #(
  parameter int TICK_CYCLES = sdb_pkg::TICK_CYCLES,
  parameter int WARN_LIMIT_S = sdb_pkg::WARN_ESCALATE_S
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic callValid,
  input wire logic [7:0] callRequestByte,
  input wire logic linkOk,
  input wire logic guardClosed,
  input wire logic actuatorValid,
  input wire logic boltLocked,
  input wire logic turretAtRest,
  input wire logic upstreamSafetyInA,
  input wire logic upstreamSafetyInB,
  input wire logic faultOutA,
  input wire logic faultOutB,
  input wire logic faultCross,
  input wire logic faultTemp,
  input wire logic faultActuator,
  input wire logic faultInternal,
  input wire logic handleMisplaced,
  output logic magnetOn,
  output logic safetyOutA,
  output logic safetyOutB,
  output logic [7:0] responseStatusByte,
  output logic [7:0] diagWarningByte,
  output logic [7:0] diagErrorByte
);
  import sdb_pkg::*;

  localparam int NIN = 16;

  // Two-stage synchronisers; stage one is read only by stage two.
  logic [NIN-1:0] syncA_reg;
  logic [NIN-1:0] syncB_reg;
  logic [7:0] callSyncA_reg;
  logic [7:0] callSyncB_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      callSyncA_reg <= BYTE_RESET;
      callSyncB_reg <= BYTE_RESET;
    end else begin
      syncA_reg <= {callValid, linkOk, guardClosed, actuatorValid, boltLocked, turretAtRest,
                    upstreamSafetyInA, upstreamSafetyInB, faultOutA, faultOutB, faultCross,
                    faultTemp, faultActuator, faultInternal, handleMisplaced, 1'b0};
      syncB_reg <= syncA_reg;
      callSyncA_reg <= callRequestByte;
      callSyncB_reg <= callSyncA_reg;
    end
  end

  logic sCallValid, sLinkOk, sClosed, sActValid, sLocked, sRest, sInA, sInB;
  logic sOutA, sOutB, sCross, sTemp, sActFault, sInternal, sHandle;
  assign {sCallValid, sLinkOk, sClosed, sActValid, sLocked, sRest, sInA, sInB,
          sOutA, sOutB, sCross, sTemp, sActFault, sInternal, sHandle} = syncB_reg[NIN-1:1];

  // Call byte is taken on the strobe's rising edge; the data is stable by then.
  logic callValidDly_reg;
  logic [7:0] callReg_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      callValidDly_reg <= 1'b0;
    end else begin
      callValidDly_reg <= sCallValid;
    end
  end
  wire callTake = sCallValid && !callValidDly_reg && sLinkOk;

  // A dropped link freezes the last call byte, so nothing switches. [RULE_14]
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      callReg_reg <= BYTE_RESET;
    end else if (callTake) begin
      callReg_reg <= callSyncB_reg;
    end
  end

  // The magnet is driven from the call bit whatever the lock principle. [RULE_02]
  assign magnetOn = callReg_reg[CALL_MAGNET];

  // Reset request is the falling edge of call bit 7.
  wire resetEdge = callTake && callReg_reg[CALL_RESET] && !callSyncB_reg[CALL_RESET];

  // Slow tick for the escalation timer.
  sdb_tick_if tickIf ();
  sdb_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) uTick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tickIf(tickIf)
  );

  wire [4:0] warnCause = {sTemp, sCross, sOutB, sOutA, 1'b0} >> 1;
  wire anyWarnCause = |warnCause[3:0];
  wire hardCause = sActFault || sInternal || sHandle;

  sdb_health_t health_reg;
  logic [15:0] warnSec_reg;
  logic [7:0] errLatch_reg;
  assign tickIf.hold = !anyWarnCause || (health_reg == SDB_FAULT);

  // Seconds the warning has stood; a vanished cause clears it at once.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !anyWarnCause) begin
      warnSec_reg <= 16'h0;
    end else if (tickIf.tick && warnSec_reg != 16'(WARN_LIMIT_S)) begin
      warnSec_reg <= warnSec_reg + 16'h1;
    end
  end
  wire warnExpired = anyWarnCause && (warnSec_reg == 16'(WARN_LIMIT_S)); // [RULE_08]

  // Latched error causes; a new cause wins over a clear in the same cycle.
  wire [7:0] errSet = {sHandle, 1'b0, sInternal, sActFault,
                       sTemp & warnExpired, sCross & warnExpired,
                       sOutB & warnExpired, sOutA & warnExpired};
  wire clearReq = resetEdge || !sClosed; // [RULE_13]
  wire causeGone = !hardCause && !anyWarnCause;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      errLatch_reg <= BYTE_RESET;
    end else if (clearReq && causeGone) begin
      errLatch_reg <= errSet; // [RULE_13]
    end else begin
      errLatch_reg <= errLatch_reg | errSet; // [RULE_08] [RULE_11] [RULE_12]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      health_reg <= SDB_OK;
    end else if (|errLatch_reg || |errSet) begin
      health_reg <= SDB_FAULT;
    end else if (anyWarnCause) begin
      health_reg <= SDB_WARN;
    end else begin
      health_reg <= SDB_OK;
    end
  end

  // Safety outputs need both inputs, a locked valid actuator and no fault.
  wire inputsOk = sInA && sInB; // [RULE_05]
  wire lockedOk = sActValid && sLocked; // [RULE_04]
  wire enable = inputsOk && lockedOk && sClosed && (health_reg != SDB_FAULT) && !(|errSet);
  // Unlocking is impossible while the turret is pulled out; locking needs it at rest.
  wire possible = sClosed && sRest; // [RULE_03] [RULE_06] [RULE_07]

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      safetyOutA <= 1'b0;
      safetyOutB <= 1'b0;
      responseStatusByte <= BYTE_RESET;
      diagWarningByte <= BYTE_RESET;
      diagErrorByte <= BYTE_RESET;
    end else begin
      safetyOutA <= enable;
      safetyOutB <= enable;
      // All flags are set while the condition holds. [RULE_01]
      responseStatusByte[RSP_OUT_ACTIVE] <= enable; // [RULE_15]
      responseStatusByte[RSP_CLOSED_POSSIBLE] <= possible; // [RULE_03]
      responseStatusByte[RSP_LOCKED] <= lockedOk; // [RULE_04]
      responseStatusByte[3] <= 1'b0;
      responseStatusByte[RSP_INPUTS] <= inputsOk; // [RULE_05]
      responseStatusByte[RSP_ACT_VALID] <= sActValid; // [RULE_15]
      responseStatusByte[RSP_WARNING] <= anyWarnCause || !sLinkOk; // [RULE_15]
      responseStatusByte[RSP_ERROR] <= (|errLatch_reg) || (|errSet); // [RULE_15]
      diagWarningByte[DG_OUT_A] <= sOutA; // [RULE_16]
      diagWarningByte[DG_OUT_B] <= sOutB; // [RULE_16]
      diagWarningByte[DG_CROSS] <= sCross; // [RULE_16]
      diagWarningByte[DG_TEMP] <= sTemp; // [RULE_16]
      diagWarningByte[DG_ACTUATOR] <= 1'b0;
      diagWarningByte[DG_INTERNAL] <= sInternal; // [RULE_16]
      diagWarningByte[DG_COMM] <= !sLinkOk; // [RULE_10]
      diagWarningByte[DG_HANDLE] <= sHandle; // [RULE_12]
      diagErrorByte <= errLatch_reg | errSet; // [RULE_11] [RULE_12] [RULE_16]
    end
  end

  magnet_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    callTake |=> magnetOn == $past(callSyncB_reg[CALL_MAGNET])) // [RULE_02]
    else $error("Magnet does not follow call bit 0.");
  link_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !sLinkOk |=> $stable(magnetOn)) // [RULE_14]
    else $error("Magnet changed while the link was down.");
  possible_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(sClosed && sRest) |=> !responseStatusByte[RSP_CLOSED_POSSIBLE]) // [RULE_07]
    else $error("Possible flag set with turret out or guard open.");
  inputs_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 responseStatusByte[RSP_INPUTS] == $past(sInA && sInB)) // [RULE_05]
    else $error("Input flag disagrees with the safety inputs.");
  locked_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    responseStatusByte[RSP_LOCKED] |-> $past(sActValid && sLocked)) // [RULE_04]
    else $error("Locked flag set without a locked actuator.");
  escalate_fault_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    warnExpired |-> ##2 (!safetyOutA && responseStatusByte[RSP_ERROR])) // [RULE_08]
    else $error("Expired warning did not switch the outputs off.");
  comm_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !sLinkOk |=> diagWarningByte[DG_COMM]) // [RULE_10]
    else $error("Communication error not flagged.");
  actuator_err_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sActFault |=> diagErrorByte[DG_ACTUATOR] && !safetyOutA) // [RULE_11]
    else $error("Actuator fault not flagged.");
  handle_both_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sHandle |=> diagWarningByte[DG_HANDLE] && diagErrorByte[DG_HANDLE]) // [RULE_12]
    else $error("Handle flag missing from a diagnostic byte.");
  error_holds_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (|errLatch_reg && !clearReq) |=> |errLatch_reg) // [RULE_13]
    else $error("Latched error cleared without a reset condition.");
  out_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    responseStatusByte[RSP_OUT_ACTIVE] == safetyOutA) // [RULE_15]
    else $error("Output flag disagrees with safety output.");
  // A strobe seen while the link is down must leave the held call byte alone.
  call_refused_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_14]
    (sCallValid && !callValidDly_reg && !sLinkOk) |=> $stable(callReg_reg))
    else $error("Call byte taken while the link was down.");
  magnet_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_02]
    !callTake |=> $stable(magnetOn))
    else $error("Magnet changed without a taken call.");
  reset_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
    (resetEdge && causeGone) |=> (errLatch_reg == BYTE_RESET))
    else $error("Reset edge did not clear the latched errors.");
  guard_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
    (!sClosed && causeGone) |=> (errLatch_reg == BYTE_RESET))
    else $error("Open guard did not clear the latched errors.");
  warn_live_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_16]
    ##1 diagWarningByte[3:0] == $past({sTemp, sCross, sOutB, sOutA}))
    else $error("Warning bits disagree with the warning causes.");
  internal_both_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_16]
    sInternal |=> diagWarningByte[DG_INTERNAL] && diagErrorByte[DG_INTERNAL])
    else $error("Internal error missing from a diagnostic byte.");
  err_spare_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_16]
    !diagErrorByte[DG_COMM])
    else $error("Unused error bit set.");
  warn_spare_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_11]
    !diagWarningByte[DG_ACTUATOR])
    else $error("Actuator fault shown as a warning.");
  rsp_spare_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_01]
    !responseStatusByte[3])
    else $error("Unused response bit set.");
  act_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_15]
    ##1 responseStatusByte[RSP_ACT_VALID] == $past(sActValid))
    else $error("Actuator flag disagrees with the actuator input.");
  warn_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_15]
    anyWarnCause |=> responseStatusByte[RSP_WARNING])
    else $error("Warning cause not flagged in the response byte.");
  error_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_15]
    (|errLatch_reg) |=> responseStatusByte[RSP_ERROR])
    else $error("Latched error not flagged in the response byte.");
  fault_blocks_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_08]
    responseStatusByte[RSP_ERROR] |-> !safetyOutA && !safetyOutB)
    else $error("Safety output active with an error flagged.");
  outputs_equal_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_15]
    safetyOutA == safetyOutB)
    else $error("Safety outputs disagree.");
  outputs_need_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_05]
    safetyOutA |-> $past(sInA && sInB && sClosed && sActValid && sLocked))
    else $error("Safety output active without its conditions.");
  turret_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_06]
    !sRest |=> !responseStatusByte[RSP_CLOSED_POSSIBLE])
    else $error("Operation reported possible with turret pulled out.");
  guard_open_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_03]
    !sClosed |=> !responseStatusByte[RSP_CLOSED_POSSIBLE])
    else $error("Operation reported possible with guard open.");
  possible_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_07]
    (sClosed && sRest) |=> responseStatusByte[RSP_CLOSED_POSSIBLE])
    else $error("Operation not reported possible with turret at rest.");
  locked_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_04]
    (sActValid && sLocked) |=> responseStatusByte[RSP_LOCKED])
    else $error("Locked actuator not flagged.");
  // The timer only runs while a warning stands and no fault has been declared.
  tick_gated_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_08]
    tickIf.tick |-> anyWarnCause && (health_reg != SDB_FAULT))
    else $error("Escalation tick without a standing warning.");
  no_early_fault_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_08]
    (!anyWarnCause && !hardCause && errLatch_reg == BYTE_RESET) |=> !responseStatusByte[RSP_ERROR])
    else $error("Error flagged without any cause.");
  timer_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_08]
    !anyWarnCause |=> warnSec_reg == 16'h0)
    else $error("Escalation timer kept running after the warning went.");
  timer_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_08]
    (tickIf.tick && warnSec_reg != 16'(WARN_LIMIT_S)) |=> warnSec_reg == $past(warnSec_reg) + 16'h1)
    else $error("Escalation timer missed a tick.");
  comm_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_10]
    sLinkOk |=> !diagWarningByte[DG_COMM])
    else $error("Communication error flagged with the link up.");
endmodule : sdb_byte_map

/* File: rtl/sdb_tick_div.sv */
/*
  Divider producing a one-cycle enable every TICK_CYCLES clocks.
  Assumes clk_sys at 40 MHz; the count is shortened in simulation by parameter.
*/
`timescale 1ns/1ps
module sdb_tick_div #(
  parameter int TICK_CYCLES = sdb_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sdb_tick_if.src tickIf
);
  import sdb_pkg::*;
  logic [31:0] cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || tickIf.hold) begin
      cnt_reg <= 32'h0;
    end else if (cnt_reg == 32'(TICK_CYCLES - 1)) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end
  assign tickIf.tick = rst_n && !tickIf.hold && (cnt_reg == 32'(TICK_CYCLES - 1));
endmodule : sdb_tick_div

/* File: testbench/sdb_gateway_model.sv */
/*
  Behavioural model of the field bus gateway that sends call bytes to the byte map.
  Assumes it shares clk_sys with the byte map and that the testbench calls send_call.
*/
`timescale 1ns/1ps
module sdb_gateway_model (
  input wire logic clk_sys,
  output logic callValid,
  output logic [7:0] callRequestByte
);
  initial begin
    callValid = 1'b0;
    callRequestByte = 8'h00;
  end
  // Sends one active-high call byte, set up and spaced as the byte map needs.
  task automatic send_call(input logic [7:0] b);
    @(posedge clk_sys);
    callRequestByte <= b;
    repeat (3) @(posedge clk_sys);
    callValid <= 1'b1;
    repeat (4) @(posedge clk_sys);
    callValid <= 1'b0;
    // Released lines show the inverse, so a stale byte is never taken by luck.
    callRequestByte <= ~b;
    repeat (4) @(posedge clk_sys);
  endtask : send_call
endmodule : sdb_gateway_model

/* File: testbench/serial_diag_byte_map_test.sv */
/*
  Self-checking testbench of the serial diagnostic byte map.
  Assumes the gateway model in its own file and shortened tick and escalation counts.
*/
`timescale 1ns/1ps
module serial_diag_byte_map_test;
  import sdb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] st = 7'h00;
  logic [6:0] flt = 7'h00;
  logic callValid;
  logic [7:0] callRequestByte;
  logic magnetOn;
  logic safetyOutA;
  logic safetyOutB;
  logic [7:0] rsp;
  logic [7:0] dWarn;
  logic [7:0] dErr;
  logic [7:0] wExp [3] = '{8'h00, 8'h20, 8'h80};
  logic [7:0] eExp [3] = '{8'h10, 8'h20, 8'h80};
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  sdb_gateway_model gw (.clk_sys(clk_sys), .callValid(callValid), .callRequestByte(callRequestByte));
  sdb_byte_map #(.TICK_CYCLES(4), .WARN_LIMIT_S(3)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .callValid(callValid), .callRequestByte(callRequestByte),
    .linkOk(st[0]), .guardClosed(st[1]), .actuatorValid(st[2]), .boltLocked(st[3]),
    .turretAtRest(st[4]), .upstreamSafetyInA(st[5]), .upstreamSafetyInB(st[6]),
    .faultOutA(flt[0]), .faultOutB(flt[1]), .faultCross(flt[2]), .faultTemp(flt[3]),
    .faultActuator(flt[4]), .faultInternal(flt[5]), .handleMisplaced(flt[6]),
    .magnetOn(magnetOn), .safetyOutA(safetyOutA), .safetyOutB(safetyOutB),
    .responseStatusByte(rsp), .diagWarningByte(dWarn), .diagErrorByte(dErr)
  );
  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic drive(input logic [6:0] s, input logic [6:0] f);
    @(posedge clk_sys);
    st <= s;
    flt <= f;
    settle(6);
  endtask : drive
  task automatic t_status;
    drive(7'h7f, 7'h00);
    chk(rsp, 8'h37);
    chk({6'h00, safetyOutB, safetyOutA}, 8'h03);
    drive(7'h6f, 7'h00);
    chk(rsp, 8'h35);
    drive(7'h5f, 7'h00);
    chk(rsp, 8'h26);
    drive(7'h3f, 7'h00);
    chk(rsp, 8'h26);
    chk({6'h00, safetyOutB, safetyOutA}, 8'h00);
    drive(7'h7b, 7'h00);
    chk(rsp, 8'h12);
    chk({6'h00, safetyOutB, safetyOutA}, 8'h00);
    drive(7'h77, 7'h00);
    chk(rsp, 8'h32);
    chk({6'h00, safetyOutB, safetyOutA}, 8'h00);
    drive(7'h7f, 7'h00);
  endtask : t_status
  task automatic t_magnet;
    gw.send_call(8'h01);
    settle(2);
    chk({7'h00, magnetOn}, 8'h01);
    drive(7'h7e, 7'h00);
    chk(dWarn, 8'h40);
    chk({7'h00, rsp[RSP_WARNING]}, 8'h01);
    gw.send_call(8'h00);
    chk({7'h00, magnetOn}, 8'h01);
    drive(7'h7f, 7'h00);
    // Clears anything the link outage may have latched before the next scenarios.
    gw.send_call(8'h80);
    gw.send_call(8'h00);
    settle(2);
    chk({7'h00, magnetOn}, 8'h00);
    chk(rsp, 8'h37);
  endtask : t_magnet
  task automatic t_warnings;
    for (int i = 0; i < 4; i++) begin
      drive(7'h7f, 7'h01 << i);
      chk(dWarn, 8'h01 << i);
      chk(rsp, 8'h77);
      settle(30);
      chk(dErr, 8'h01 << i);
      chk(rsp, 8'hf6);
      chk({6'h00, safetyOutB, safetyOutA}, 8'h00);
      drive(7'h7f, 7'h00);
      gw.send_call(8'h80);
      gw.send_call(8'h00);
      settle(2);
      chk(dErr, 8'h00);
      chk(rsp, 8'h37);
    end
  endtask : t_warnings
  task automatic t_hard;
    for (int k = 0; k < 3; k++) begin
      drive(7'h7f, 7'h10 << k);
      chk(dWarn, wExp[k]);
      chk(dErr, eExp[k]);
      chk(rsp, 8'hb6);
      drive(7'h7f, 7'h00);
      chk(dErr, eExp[k]);
      drive(7'h7d, 7'h00);
      chk(dErr, 8'h00);
      chk(rsp, 8'h34);
      drive(7'h7f, 7'h00);
    end
  endtask : t_hard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    settle(6);
    chk(rsp, BYTE_RESET);
    chk(dWarn, BYTE_RESET);
    chk(dErr, BYTE_RESET);
    chk({7'h00, magnetOn}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(1);
    t_status();
    t_magnet();
    t_warnings();
    t_hard();
    close_out();
  end
endmodule : serial_diag_byte_map_test
